// >>> design/chan_edge_detect.sv
// input capture edge detector for the channel pin
`timescale 1ns/1ps
module chan_edge_detect
  import timer_chan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       pinIn,
  input  wire logic [1:0] edgeSel,
  input  wire logic       enable,
  output logic            edgeEvt
);
  logic pinPrev_r;
  wire  riseSeen = pinIn & ~pinPrev_r;
  wire  fallSeen = ~pinIn & pinPrev_r;

  // previous level is kept in every mode, so a pin that moved just before
  // the switch into capture can still look like an edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pinPrev_r <= 1'b0;
    end else begin
      pinPrev_r <= pinIn; // [RQ16]
    end
  end

  // edge choice per select field; zero select never fires
  assign edgeEvt = enable & ((edgeSel[0] & riseSeen) | (edgeSel[1] & fallSeen)); // [RQ12]
endmodule // chan_edge_detect

// >>> design/chan_pin_drive.sv
// output level of the channel pin for compare and pwm modes
`timescale 1ns/1ps
module chan_pin_drive
  import timer_chan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  chan_mode_t      mode,
  input  wire logic [1:0] edgeSel,
  input  wire logic       matchEvt,
  input  wire logic       wrapEvt,
  input  wire logic       countingUp,
  output logic            pinOut
);
  logic pinOut_r;
  logic pinOut_nxt;
  wire  highTrue = (edgeSel == ELS_FALL);

  always_comb begin
    pinOut_nxt = pinOut_r;
    case (mode)
      MODE_COMPARE: begin
        if (matchEvt) begin
          case (edgeSel) // [RQ13]
            ELS_RISE: pinOut_nxt = ~pinOut_r;
            ELS_FALL: pinOut_nxt = 1'b0;
            ELS_BOTH: pinOut_nxt = 1'b1;
            default:  pinOut_nxt = pinOut_r;
          endcase
        end
      end
      MODE_EDGE_PWM: begin
        // period starts at counter wrap, compare ends the active pulse
        if (matchEvt) begin
          pinOut_nxt = ~highTrue; // [RQ14]
        end else if (wrapEvt) begin
          pinOut_nxt = highTrue;
        end
      end
      MODE_CENTER_PWM: begin
        if (matchEvt) begin
          pinOut_nxt = countingUp ? ~highTrue : highTrue; // [RQ15]
        end
      end
      default: pinOut_nxt = pinOut_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinOut_r <= 1'b0;
    end else begin
      pinOut_r <= pinOut_nxt;
    end
  end

  assign pinOut = pinOut_r;
endmodule // chan_pin_drive

// >>> design/timer_chan_pkg.sv
// shared constants, types and mode decode for one timer channel
package timer_chan_pkg;
  localparam int          ADDR_W      = 2;
  localparam logic [1:0]  REG_SC      = 2'h0;
  localparam logic [1:0]  REG_VAL_HI  = 2'h1;
  localparam logic [1:0]  REG_VAL_LO  = 2'h2;
  localparam int          FLAG_BIT    = 7;
  localparam int          IE_BIT      = 6;
  localparam int          MSB_BIT     = 5;
  localparam int          MSA_BIT     = 4;
  localparam int          ELS_HI      = 3;
  localparam int          ELS_LO      = 2;
  localparam logic [7:0]  SC_RESET    = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam logic [1:0]  ELS_OFF     = 2'h0;
  localparam logic [1:0]  ELS_RISE    = 2'h1;
  localparam logic [1:0]  ELS_FALL    = 2'h2;
  localparam logic [1:0]  ELS_BOTH    = 2'h3;
  localparam int          STABLE_CYCLES = 2;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } chan_mode_t;

  function automatic chan_mode_t decodeMode(input logic centerSel, input logic msHi,
                                            input logic msLo);
    chan_mode_t m;
    m = MODE_CAPTURE;
    if (centerSel) begin
      m = MODE_CENTER_PWM;
    end else if (msHi) begin
      m = MODE_EDGE_PWM;
    end else if (msLo) begin
      m = MODE_COMPARE;
    end
    return m;
  endfunction
endpackage

// >>> design/timer_channel_control.sv
// status, control and value registers of one 16-bit timer channel
//
// Behaviour
// RQ1: capture mode: selected pin edge sets flag
// RQ2: compare or edge pwm: match sets flag
// RQ3: center pwm: every match sets flag
// RQ4: interrupt request while flag and enable set
// RQ5: flag clears after status read, zero write
// RQ6: new event between steps cancels clearing
// RQ7: reset clears flag; writing one ignored
// RQ8: interrupt enable read/write bit 6, reset zero
// RQ9: mode bit 5 set selects edge pwm
// RQ10: mode bits 00 capture, 01 compare
// RQ11: edge field zero releases the pin
// RQ12: capture edge: rising, falling or both
// RQ13: compare pin action: none, toggle, clear, set
// RQ14: edge pwm polarity from edge field
// RQ15: center pwm ignores mode bits, sets polarity
// RQ16: unstable pin at mode change may flag
// RQ17: software clears flags after reconfiguring channel
// RQ18: center select forces center pwm everywhere
// RQ19: status write resets value byte latch
// RQ20: event beats simultaneous completing clear write
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module timer_channel_control
  import timer_chan_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        wrData,
  input  wire logic              wrStrobe,
  input  wire logic              rdStrobe,
  output logic      [7:0]        rdData,
  input  wire logic [15:0]       counter,
  input  wire logic              countingUp,
  input  wire logic              centerAlignedSelect,
  input  wire logic              chanPinIn,
  output logic                   chanPinOut,
  output logic                   chanPinOe,
  output logic                   chanPinReleased,
  output logic                   chanIrq
);
  logic        chanEventFlag_r;
  logic        chanIrqEnable_r;
  logic        modeSelectHi_r;
  logic        modeSelectLo_r;
  logic [1:0]  edgeLevelSelect_r;
  logic        clearArmed_r;
  logic        chanEventFlag_nxt;
  logic        clearArmed_nxt;
  logic [15:0] chanValue_r;
  logic [15:0] chanValue_nxt;
  logic [15:0] rdBuf_r;
  logic        rdLatched_r;
  logic        rdFirstHi_r;
  logic [7:0]  wrBufHi_r;
  logic [7:0]  wrBufLo_r;
  logic        wrHiDone_r;
  logic        wrLoDone_r;
  logic        matchPrev_r;
  logic [7:0]  rdData_r;
  logic        captureEvt;
  chan_mode_t  chanMode;

  wire scWrite    = wrStrobe & (regAddr == REG_SC);
  wire scRead     = rdStrobe & (regAddr == REG_SC);
  wire hiWrite    = wrStrobe & (regAddr == REG_VAL_HI);
  wire loWrite    = wrStrobe & (regAddr == REG_VAL_LO);
  wire hiRead     = rdStrobe & (regAddr == REG_VAL_HI);
  wire loRead     = rdStrobe & (regAddr == REG_VAL_LO);
  wire valRead    = hiRead | loRead;
  wire isCapture  = (chanMode == MODE_CAPTURE);
  wire isCenter   = (chanMode == MODE_CENTER_PWM);
  wire pinActive  = (edgeLevelSelect_r != ELS_OFF);
  wire matchNow   = (counter == chanValue_r);
  // a counter may hold one value for many bus cycles, so only the entry counts
  wire matchEvt   = matchNow & ~matchPrev_r;
  wire wrapEvt    = (counter == COUNT_ZERO) & ~isCenter;
  wire compareEvt = ~isCapture & matchEvt; // [RQ2] [RQ3]
  wire chanEvt    = captureEvt | compareEvt;
  wire clearWrite = scWrite & ~wrData[FLAG_BIT] & clearArmed_r;
  wire [7:0] scView = {chanEventFlag_r, chanIrqEnable_r, modeSelectHi_r, modeSelectLo_r,
                       edgeLevelSelect_r, 2'h0};
  wire hiDoneNow  = wrHiDone_r | hiWrite;
  wire loDoneNow  = wrLoDone_r | loWrite;
  wire [7:0] hiNow = hiWrite ? wrData : wrBufHi_r;
  wire [7:0] loNow = loWrite ? wrData : wrBufLo_r;
  wire wrTransfer = hiDoneNow & loDoneNow & ~isCapture;
  wire [15:0] rdSource = (isCapture & rdLatched_r) ? rdBuf_r : chanValue_r;

  // center select overrides the per-channel mode bits
  assign chanMode = decodeMode(centerAlignedSelect, modeSelectHi_r, modeSelectLo_r); // [RQ9] [RQ10] [RQ18]

  chan_edge_detect u_edge (
    .clk     (clk),
    .rst     (rst),
    .pinIn   (chanPinIn),
    .edgeSel (edgeLevelSelect_r),
    .enable  (isCapture & pinActive),
    .edgeEvt (captureEvt)
  ); // [RQ1] [RQ11]

  chan_pin_drive u_drive (
    .clk        (clk),
    .rst        (rst),
    .mode       (chanMode),
    .edgeSel    (edgeLevelSelect_r),
    .matchEvt   (matchEvt),
    .wrapEvt    (wrapEvt),
    .countingUp (countingUp),
    .pinOut     (chanPinOut)
  );

  // flag: hardware set outranks the clear that completes the handshake
  always_comb begin
    chanEventFlag_nxt = chanEventFlag_r;
    clearArmed_nxt    = clearArmed_r;
    if (chanEvt) begin
      chanEventFlag_nxt = 1'b1; // [RQ20]
      clearArmed_nxt    = 1'b0; // [RQ6]
    end else if (clearWrite) begin
      chanEventFlag_nxt = 1'b0; // [RQ5]
      clearArmed_nxt    = 1'b0;
    end else if (scRead & chanEventFlag_r) begin
      clearArmed_nxt    = 1'b1; // [RQ5]
    end
  end

  always_comb begin
    chanValue_nxt = chanValue_r;
    if (isCapture & captureEvt) begin
      chanValue_nxt = counter;
    end else if (wrTransfer) begin
      chanValue_nxt = {hiNow, loNow};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chanEventFlag_r <= SC_RESET[FLAG_BIT]; // [RQ7]
      clearArmed_r    <= 1'b0;
    end else begin
      chanEventFlag_r <= chanEventFlag_nxt; // [RQ7]
      clearArmed_r    <= clearArmed_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chanIrqEnable_r   <= SC_RESET[IE_BIT];
      modeSelectHi_r    <= SC_RESET[MSB_BIT];
      modeSelectLo_r    <= SC_RESET[MSA_BIT];
      edgeLevelSelect_r <= SC_RESET[ELS_HI:ELS_LO];
    end else if (scWrite) begin
      chanIrqEnable_r   <= wrData[IE_BIT]; // [RQ8]
      modeSelectHi_r    <= wrData[MSB_BIT];
      modeSelectLo_r    <= wrData[MSA_BIT];
      edgeLevelSelect_r <= wrData[ELS_HI:ELS_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chanValue_r <= VALUE_RESET;
      matchPrev_r <= 1'b0;
    end else begin
      chanValue_r <= chanValue_nxt;
      matchPrev_r <= matchNow;
    end
  end

  // byte write buffer; a status write drops a half-written pair
  always_ff @(posedge clk) begin
    if (rst | scWrite | wrTransfer) begin
      wrHiDone_r <= 1'b0; // [RQ19]
      wrLoDone_r <= 1'b0;
    end else begin
      wrHiDone_r <= hiDoneNow;
      wrLoDone_r <= loDoneNow;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrBufHi_r <= 8'h00;
      wrBufLo_r <= 8'h00;
    end else begin
      wrBufHi_r <= hiNow;
      wrBufLo_r <= loNow;
    end
  end

  // read latch: in capture mode, first byte read freezes both until the other byte is read
  always_ff @(posedge clk) begin
    if (rst | scWrite) begin
      rdLatched_r <= 1'b0; // [RQ19]
      rdFirstHi_r <= 1'b0;
      rdBuf_r     <= VALUE_RESET;
    end else if (valRead & isCapture) begin
      if (!rdLatched_r) begin
        rdLatched_r <= 1'b1;
        rdFirstHi_r <= hiRead;
        rdBuf_r     <= chanValue_r;
      end else if (hiRead != rdFirstHi_r) begin
        rdLatched_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else if (scRead) begin
      rdData_r <= scView;
    end else if (hiRead) begin
      rdData_r <= rdSource[15:8];
    end else if (loRead) begin
      rdData_r <= rdSource[7:0];
    end else begin
      rdData_r <= 8'h00;
    end
  end

  assign rdData          = rdData_r;
  assign chanIrq         = chanEventFlag_r & chanIrqEnable_r; // [RQ4]
  assign chanPinReleased = ~pinActive; // [RQ11]
  // capture keeps the pin an input; a released pin is never driven
  assign chanPinOe       = pinActive & ~isCapture; // [RQ11]

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence armRead;
    scRead && chanEventFlag_r && !chanEvt;
  endsequence

  sequence quietZeroWrite;
    scWrite && !wrData[FLAG_BIT] && !chanEvt;
  endsequence

  chk_capture_sets_flag: assert property (captureEvt |=> chanEventFlag_r) // [RQ1]
    else $error("capture edge did not set flag");
  chk_compare_sets_flag: assert property ( // [RQ2]
    (chanMode == MODE_COMPARE || chanMode == MODE_EDGE_PWM) && matchEvt |=> chanEventFlag_r)
    else $error("compare match did not set flag");
  chk_center_sets_flag: assert property (isCenter && matchEvt |=> chanEventFlag_r) // [RQ3]
    else $error("center pwm match did not set flag");
  chk_irq_request: assert property ( // [RQ4]
    $rose(chanEventFlag_r) && chanIrqEnable_r |-> chanIrq ##1
      (chanIrq || !chanEventFlag_r || !chanIrqEnable_r))
    else $error("interrupt request missing");
  // a bus master spends one idle cycle between the read and the zero write
  chk_clear_handshake: assert property ( // [RQ5]
    armRead ##1 !chanEvt ##1 quietZeroWrite |=> !chanEventFlag_r)
    else $error("handshake did not clear flag");
  chk_clear_needs_read: assert property ($fell(chanEventFlag_r) |-> $past(clearArmed_r)) // [RQ5]
    else $error("flag cleared without prior status read");
  chk_event_cancels: assert property (chanEvt |=> chanEventFlag_r && !clearArmed_r) // [RQ6]
    else $error("event did not cancel clear sequence");
  chk_one_ignored: assert property ( // [RQ7]
    scWrite && wrData[FLAG_BIT] && !chanEventFlag_r && !chanEvt |=> !chanEventFlag_r)
    else $error("writing one set the flag");
  chk_enable_write: assert property (scWrite |=> chanIrqEnable_r == $past(wrData[IE_BIT])) // [RQ8]
    else $error("enable bit not written");
  chk_pin_released: assert property (!pinActive |-> !chanPinOe && chanPinReleased) // [RQ11]
    else $error("released pin still driven");
  chk_sc_unlatch: assert property (scWrite |=> !rdLatched_r && !wrHiDone_r && !wrLoDone_r) // [RQ19]
    else $error("status write left value latch set");
  chk_set_beats_clear: assert property (chanEvt && clearWrite |=> chanEventFlag_r) // [RQ20]
    else $error("clear beat a coincident event");

  // pin action follows the mode and field seen at the match edge
  sequence cmpMatch;
    chanMode == MODE_COMPARE && matchEvt;
  endsequence

  sequence pwmMatch;
    chanMode == MODE_EDGE_PWM && matchEvt && pinActive;
  endsequence

  chk_flag_has_cause: assert property ($rose(chanEventFlag_r) |-> $past(chanEvt)) // [RQ7]
    else $error("flag set without a channel event");
  chk_arm_needs_read: assert property ($rose(clearArmed_r) |-> $past(scRead)) // [RQ5]
    else $error("clear armed without status read");
  chk_capture_loads: assert property (captureEvt |=> chanValue_r == $past(counter)) // [RQ1]
    else $error("capture did not load counter");
  chk_status_readback: assert property ( // [RQ8]
    scRead |=> rdData[IE_BIT] == $past(chanIrqEnable_r))
    else $error("enable bit not readable");
  chk_cmp_toggle: assert property ( // [RQ13]
    cmpMatch ##0 edgeLevelSelect_r == ELS_RISE |=> chanPinOut != $past(chanPinOut))
    else $error("compare toggle missing");
  chk_cmp_clear: assert property ( // [RQ13]
    cmpMatch ##0 edgeLevelSelect_r == ELS_FALL |=> !chanPinOut)
    else $error("compare clear missing");
  chk_cmp_set: assert property ( // [RQ13]
    cmpMatch ##0 edgeLevelSelect_r == ELS_BOTH |=> chanPinOut)
    else $error("compare set missing");
  // a match that lands on the wrap count still ends the pulse
  chk_pwm_high_true: assert property ( // [RQ14]
    pwmMatch ##0 edgeLevelSelect_r == ELS_FALL |=> !chanPinOut)
    else $error("high-true pwm not cleared on match");
  chk_pwm_low_true: assert property ( // [RQ14]
    pwmMatch ##0 edgeLevelSelect_r[0] |=> chanPinOut)
    else $error("low-true pwm not set on match");
  chk_center_up: assert property ( // [RQ15]
    isCenter && matchEvt && countingUp && edgeLevelSelect_r == ELS_FALL |=> !chanPinOut)
    else $error("center pwm up match did not clear");
  chk_center_down: assert property ( // [RQ15]
    isCenter && matchEvt && !countingUp && edgeLevelSelect_r == ELS_FALL |=> chanPinOut)
    else $error("center pwm down match did not set");
endmodule // timer_channel_control

// >>> dv/chan_far_side.sv
// far side model: channel pin, main counter and timer-wide center select
`timescale 1ns/1ps
module chan_far_side (
  input  wire logic        clk,
  output logic      [15:0] counter,
  output logic             countingUp,
  output logic             centerSel,
  output logic             pinLevel
);
  initial begin
    counter    = 16'h0000;
    countingUp = 1'b1;
    centerSel  = 1'b0;
    pinLevel   = 1'b0;
  end
  // changes land after an edge and then hold, so the pin is stable for many cycles
  task automatic setCount(input logic [15:0] c, input logic up);
    @(posedge clk);
    counter    <= c;
    countingUp <= up;
  endtask
  task automatic setPin(input logic v);
    @(posedge clk);
    pinLevel <= v;
  endtask
  task automatic setCenter(input logic v);
    @(posedge clk);
    centerSel <= v;
  endtask
endmodule // chan_far_side

// >>> dv/test_timer_channel_control.sv
// self-checking bench for the timer channel status and control block
`timescale 1ns/1ps
module test_timer_channel_control
  import timer_chan_pkg::*;
;
  logic              clk      = 1'b0;
  logic              rst      = 1'b1;
  logic [ADDR_W-1:0] regAddr  = 2'h0;
  logic [7:0]        wrData   = 8'h00;
  logic              wrStrobe = 1'b0;
  logic              rdStrobe = 1'b0;
  logic [7:0]        rdData;
  logic [15:0]       counter;
  logic              countingUp;
  logic              centerSel;
  logic              chanPinIn;
  logic              chanPinOut;
  logic              chanPinOe;
  logic              chanPinReleased;
  logic              chanIrq;
  logic [3:0]        pins;
  logic [7:0]        got;
  int                failCount = 0;
  int                checked   = 0;

  assign pins = {chanIrq, chanPinOe, chanPinReleased, chanPinOut};

  always #50 clk = ~clk;

  chan_far_side i_far (
    .clk        (clk),
    .counter    (counter),
    .countingUp (countingUp),
    .centerSel  (centerSel),
    .pinLevel   (chanPinIn)
  );

  timer_channel_control i_dut (
    .clk                 (clk),
    .rst                 (rst),
    .regAddr             (regAddr),
    .wrData              (wrData),
    .wrStrobe            (wrStrobe),
    .rdStrobe            (rdStrobe),
    .rdData              (rdData),
    .counter             (counter),
    .countingUp          (countingUp),
    .centerAlignedSelect (centerSel),
    .chanPinIn           (chanPinIn),
    .chanPinOut          (chanPinOut),
    .chanPinOe           (chanPinOe),
    .chanPinReleased     (chanPinReleased),
    .chanIrq             (chanIrq)
  );

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  // flags land one edge after their cause; a second edge gives margin
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic clearFlag(input logic [7:0] cfg);
    rd(REG_SC, got);
    wr(REG_SC, cfg);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic testReset();
    rd(REG_SC, got);
    chk("status after reset", SC_RESET, got);
    chk("pins after reset", 8'h02, {4'h0, pins});
    wr(REG_SC, 8'hC3);
    rd(REG_SC, got);
    chk("flag write ignored", 8'h40, got);
    rd(2'h3, got);
    chk("unmapped read", 8'h00, got);
  endtask

  task automatic testCompare();
    // value bytes only load outside capture, so pick the mode first
    wr(REG_SC, 8'h54);
    wr(REG_VAL_HI, 8'h00);
    wr(REG_VAL_LO, 8'h10);
    i_far.setCount(16'h0010, 1'b1);
    settle();
    chk("compare toggle", 8'h0D, {4'h0, pins});
    wr(REG_SC, 8'h54);
    settle();
    chk("clear without read", 8'h0D, {4'h0, pins});
    rd(REG_SC, got);
    chk("flag readable", 8'hD4, got);
    wr(REG_SC, 8'h54);
    settle();
    chk("clear after read", 8'h05, {4'h0, pins});
    i_far.setCount(16'h0000, 1'b1);
    i_far.setCount(16'h0010, 1'b1);
    settle();
    rd(REG_SC, got);
    i_far.setCount(16'h0000, 1'b1);
    i_far.setCount(16'h0010, 1'b1);
    wr(REG_SC, 8'h54);
    settle();
    chk("event cancels clear", 8'h0D, {4'h0, pins});
    rd(REG_SC, got);
    i_far.setCount(16'h0000, 1'b1);
    // match and completing zero write reach the block at the same edge
    fork
      i_far.setCount(16'h0010, 1'b1);
      wr(REG_SC, 8'h54);
    join
    settle();
    chk("event beats clear", 8'h0C, {4'h0, pins});
    clearFlag(8'h50);
    i_far.setCount(16'h0000, 1'b1);
    i_far.setCount(16'h0010, 1'b1);
    settle();
    chk("software compare", 8'h0A, {4'h0, pins[3:1], 1'b0});
    // set first, then clear, so each action moves the pin
    for (int e = 3; e > 1; e--) begin
      clearFlag({4'h5, e[1:0], 2'h0});
      i_far.setCount(16'h0000, 1'b1);
      i_far.setCount(16'h0010, 1'b1);
      settle();
      chk("compare level", {7'h00, e[0]}, {7'h00, chanPinOut});
    end
  endtask

  task automatic testCapture();
    i_far.setCount(16'h1234, 1'b1);
    for (int e = 1; e < 4; e++) begin
      clearFlag({4'h4, e[1:0], 2'h0});
      i_far.setPin(1'b1);
      settle();
      chk("rise capture", {7'h00, e[0]}, {7'h00, chanIrq});
      clearFlag({4'h4, e[1:0], 2'h0});
      i_far.setPin(1'b0);
      settle();
      chk("fall capture", {7'h00, e[1]}, {7'h00, chanIrq});
    end
    rd(REG_VAL_HI, got);
    chk("captured high", 8'h12, got);
    rd(REG_VAL_LO, got);
    chk("captured low", 8'h34, got);
  endtask

  task automatic testPwm();
    wr(REG_SC, 8'h20);
    wr(REG_VAL_HI, 8'h00);
    wr(REG_VAL_LO, 8'h10);
    for (int e = 2; e > 0; e--) begin
      wr(REG_SC, {4'h2, e[1:0], 2'h0});
      i_far.setCount(16'h0000, 1'b1);
      settle();
      chk("pwm period start", {7'h00, e[1]}, {7'h00, chanPinOut});
      i_far.setCount(16'h0010, 1'b1);
      settle();
      chk("pwm compare", {7'h00, e[0]}, {7'h00, chanPinOut});
    end
    // mode bits say compare here; center select must override them
    i_far.setCenter(1'b1);
    clearFlag(8'h58);
    i_far.setCount(16'h0000, 1'b1);
    i_far.setCount(16'h0010, 1'b1);
    settle();
    chk("center up match", 8'h02, {6'h00, chanIrq, chanPinOut});
    clearFlag(8'h58);
    i_far.setCount(16'h0011, 1'b0);
    i_far.setCount(16'h0010, 1'b0);
    settle();
    chk("center down match", 8'h03, {6'h00, chanIrq, chanPinOut});
    clearFlag(8'h5C);
    i_far.setCount(16'h0011, 1'b0);
    i_far.setCount(16'h0010, 1'b0);
    settle();
    chk("center low-true down", 8'h02, {6'h00, chanIrq, chanPinOut});
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testCompare();
    testCapture();
    testPwm();
    conclude();
  end

  initial begin
    repeat (3000) @(posedge clk);
    failCount++;
    conclude();
  end
endmodule // test_timer_channel_control
